// ---- design/byte_host_bus.sv ----
// Byte-wide host bus master, multiplexed address/data form.
// Assumes an external latch and synchronous peripherals on the far side.
// Notes on behaviour
// - Runs only when top mode selects byte bus
// - Muxed variant when host-bus mode is zero
// - Address low byte shares data lines 0-7
// - Drive latch strobe; latch holds address
// - Separate read and write data strobes
// - Option field picks latch and chip selects
// - One or two chip selects, one each
`timescale 1ns/1ps
`include "byte_host_bus_cfg.svh"
module byte_host_bus
   import byte_host_bus_pkg::*;
#(
   parameter int CS_COUNT = 4
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Configuration
   input wire logic [3:0] INTERFACE_TOP_CONFIG,
   input wire logic [3:0] HOST_BUS_CONFIG,
   input wire logic [1:0] CHIP_SELECT_OPTION_FIELD,
   // Request and answer
   input wire logic REQ_VALID,
   input wire byte_host_bus_pkg::request_type REQ,
   output logic REQ_READY,
   output logic RESP_VALID,
   output logic [7:0] RESP_RDATA,
   // Pins
   input wire logic [7:0] SHARED_LINE_IN,
   output byte_host_bus_pkg::pins_type PINS
);
   import byte_host_bus_pkg::*;

   typedef enum logic [2:0] {IDLE, ADDR, HOLD, STROBE, DONE} state_type;
   state_type state_reg;
   logic [3:0] count_reg;
   request_type req_reg;
   logic [1:0] option_reg;
   logic enabled;
   logic ale_w;
   logic [3:0] cs_w;

   assign enabled = (INTERFACE_TOP_CONFIG == `TOP_MODE_BYTE_HB) &&
                    (HOST_BUS_CONFIG == `HB_MODE_MUXED);

   // Access sequencer
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= IDLE;
         count_reg <= 4'h0;
         req_reg <= '0;
         option_reg <= 2'h0;
      end else begin
         case (state_reg)
            IDLE: begin
               if (REQ_VALID && enabled) begin
                  req_reg <= REQ;
                  option_reg <= CHIP_SELECT_OPTION_FIELD;
                  count_reg <= `ALE_CYCLES;
                  state_reg <= ADDR;
               end
            end
            ADDR: begin
               if (count_reg == 4'h1) begin
                  count_reg <= `HOLD_CYCLES;
                  state_reg <= HOLD;
               end else begin
                  count_reg <= count_reg - 4'h1;
               end
            end
            HOLD: begin
               if (count_reg == 4'h1) begin
                  count_reg <= `STROBE_CYCLES;
                  state_reg <= STROBE;
               end else begin
                  count_reg <= count_reg - 4'h1;
               end
            end
            STROBE: begin
               if (count_reg == 4'h1) begin
                  state_reg <= DONE;
               end else begin
                  count_reg <= count_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= IDLE;
            end
         endcase
      end
   end

   cs_decode u_cs (
      .option(option_reg),
      .cs_index(req_reg.cs_index),
      .active(state_reg != IDLE && state_reg != DONE),
      .ale_phase(state_reg == ADDR),
      .ale(ale_w),
      .cs_n(cs_w)
   );

   // Registered pin drive
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PINS <= '{addr: 28'h000_0000, ad_out: 8'h00, ad_oe: 8'h00,
                   ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 4'hf};
      end else begin
         // Full address, low byte included, on dedicated lines
         PINS.addr <= req_reg.addr;
         PINS.ale <= ale_w;
         // Chip selects, one active at most
         PINS.cs_n <= cs_w;
         // Address on shared lines during latch phase
         if (state_reg == ADDR || state_reg == HOLD) begin
            PINS.ad_out <= req_reg.addr[7:0];
            PINS.ad_oe <= 8'hff;
         end else if (state_reg == STROBE && req_reg.write) begin
            PINS.ad_out <= req_reg.wdata;
            PINS.ad_oe <= 8'hff;
         end else begin
            PINS.ad_out <= 8'h00;
            PINS.ad_oe <= 8'h00;
         end
         PINS.rd_n <= ~(state_reg == STROBE && !req_reg.write);
         PINS.wr_n <= ~(state_reg == STROBE && req_reg.write);
      end
   end

   // Handshake and read capture
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         REQ_READY <= 1'b0;
         RESP_VALID <= 1'b0;
         RESP_RDATA <= 8'h00;
      end else begin
         REQ_READY <= (state_reg == IDLE) && enabled && !REQ_VALID;
         RESP_VALID <= (state_reg == STROBE) && (count_reg == 4'h1);
         // Sample read data at end of strobe
         if (state_reg == STROBE && count_reg == 4'h1 && !req_reg.write) begin
            RESP_RDATA <= SHARED_LINE_IN;
         end
      end
   end

   // Shared lines never driven with read strobe
   a_no_drive_read: assert property (@(posedge CLK) disable iff (RST)
      !PINS.rd_n |-> PINS.ad_oe == 8'h00)
      else $error("shared lines driven during read");
   a_strobe_excl: assert property (@(posedge CLK) disable iff (RST)
      !(!PINS.rd_n && !PINS.wr_n))
      else $error("read and write strobes together");
   a_ale_len: assert property (@(posedge CLK) disable iff (RST)
      $rose(PINS.ale) |-> PINS.ale ##1 PINS.ale ##1 !PINS.ale)
      else $error("latch strobe length wrong");
   // Address on lines under latch strobe
   a_ale_addr: assert property (@(posedge CLK) disable iff (RST)
      PINS.ale |-> PINS.ad_oe == 8'hff && PINS.ad_out == PINS.addr[7:0])
      else $error("address missing under latch strobe");
   a_cs_onehot: assert property (@(posedge CLK) disable iff (RST)
      $countones(~PINS.cs_n) <= 1)
      else $error("several chip selects active");
   // Option zero drives no chip select
   a_opt_ale: assert property (@(posedge CLK) disable iff (RST)
      state_reg == STROBE && option_reg == `CS_OPT_ALE
      |=> PINS.cs_n == 4'hf)
      else $error("chip select under latch-only option");
   // Two-select option gives no latch strobe
   a_opt_no_ale: assert property (@(posedge CLK) disable iff (RST)
      state_reg == ADDR && option_reg == `CS_OPT_TWO_CS |=> !PINS.ale)
      else $error("latch strobe under select-only option");
   a_gate: assert property (@(posedge CLK) disable iff (RST)
      state_reg == IDLE && !enabled |=> state_reg == IDLE)
      else $error("access started while disabled");
   a_wr_len: assert property (@(posedge CLK) disable iff (RST)
      $fell(PINS.wr_n) |-> !PINS.wr_n[*4] ##1 PINS.wr_n)
      else $error("write strobe length wrong");
endmodule : byte_host_bus

// ---- design/byte_host_bus_cfg.svh ----
// Constants for the byte-wide host bus, multiplexed address/data form.
// Assumes inclusion by bare name from the design modules.
`ifndef BYTE_HOST_BUS_CFG_SVH
`define BYTE_HOST_BUS_CFG_SVH
// Top-level interface mode value for byte-wide host bus
`define TOP_MODE_BYTE_HB 4'h2
// Host-bus mode value for multiplexed address/data
`define HB_MODE_MUXED 4'h0
// Chip-select option encodings
`define CS_OPT_ALE 2'h0
`define CS_OPT_ONE_CS 2'h1
`define CS_OPT_TWO_CS 2'h2
`define CS_OPT_ALE_TWO_CS 2'h3
// Phase lengths in clock cycles
`define ALE_CYCLES 4'h2
`define HOLD_CYCLES 4'h1
`define STROBE_CYCLES 4'h4
`endif

// ---- design/byte_host_bus_pkg.sv ----
// Types for the byte-wide host bus.
// Assumes the constants header sits beside it.
package byte_host_bus_pkg;
   // Request from the system side
   typedef struct packed {
      logic write;
      logic [1:0] cs_index;
      logic [27:0] addr;
      logic [7:0] wdata;
   } request_type;
   // Bus-side pin outputs
   typedef struct packed {
      logic [27:0] addr;
      logic [7:0] ad_out;
      logic [7:0] ad_oe;
      logic ale;
      logic rd_n;
      logic wr_n;
      logic [3:0] cs_n;
   } pins_type;
endpackage : byte_host_bus_pkg

// ---- design/cs_decode.sv ----
// Chip-select and latch-strobe pin mapping for the chosen option.
// Assumes inputs are registered by the caller.
`timescale 1ns/1ps
`include "byte_host_bus_cfg.svh"
module cs_decode (
   // Option and access state
   input wire logic [1:0] option,
   input wire logic [1:0] cs_index,
   input wire logic active,
   input wire logic ale_phase,
   // Resulting strobes
   output logic ale,
   output logic [3:0] cs_n
);
   // Map latch strobe and chip selects per option
   always_comb begin
      ale = 1'b0;
      cs_n = 4'hf;
      if (option == `CS_OPT_ALE) begin
         ale = ale_phase;
      end else if (option == `CS_OPT_ONE_CS) begin
         cs_n[0] = ~active;
      end else if (option == `CS_OPT_TWO_CS) begin
         cs_n[cs_index[0]] = ~active;
      end else begin
         ale = ale_phase;
         cs_n[cs_index[0]] = ~active;
      end
   end
endmodule : cs_decode

// ---- tb/periph_model.sv ----
// External address latch and one byte peripheral.
// Assumes the byte host bus pins on the same clock.
`timescale 1ns/1ps
module periph_model
   import byte_host_bus_pkg::*;
(
   // Clock, pins and mode
   input wire logic clk,
   input wire byte_host_bus_pkg::pins_type pins,
   input wire logic use_latch,
   // Wire level and captures
   output logic [7:0] line,
   output logic [7:0] lat,
   output logic [7:0] wd
);
   logic [7:0] last = 8'h00;
   logic [7:0] rdv;
   always_ff @(posedge clk) if (pins.ale) lat <= pins.ad_out;
   assign rdv = (use_latch ? lat : pins.addr[7:0]) ^ 8'ha5;
   always_ff @(posedge clk) if (!pins.wr_n) wd <= pins.ad_out;
   // Released lines toggle
   always_ff @(posedge clk) last <= line;
   assign line = (pins.ad_oe == 8'hff) ? pins.ad_out :
      (!pins.rd_n ? rdv : ~last);
endmodule : periph_model

// ---- tb/byte_host_bus_tb.sv ----
// Self-checking bench for the byte host bus.
// Assumes the peripheral model on the pins.
`timescale 1ns/1ps
module byte_host_bus_tb;
   import byte_host_bus_pkg::*;
   logic clk = 0, rst = 1, req_valid = 0, use_latch = 0;
   logic [3:0] top_cfg = 4'h2, hb_cfg = 4'h0;
   logic [1:0] opt = 2'h0;
   request_type req = '0;
   logic ready, resp;
   logic [7:0] rdata, line, lat, wd;
   pins_type pins;
   int error_cnt = 0, compares = 0;
   // Clock
   always #5 clk = ~clk;
   byte_host_bus uut (.CLK(clk), .RST(rst), .INTERFACE_TOP_CONFIG(top_cfg),
      .HOST_BUS_CONFIG(hb_cfg), .CHIP_SELECT_OPTION_FIELD(opt),
      .REQ_VALID(req_valid), .REQ(req), .REQ_READY(ready),
      .RESP_VALID(resp), .RESP_RDATA(rdata), .SHARED_LINE_IN(line),
      .PINS(pins));
   periph_model peer (.clk(clk), .pins(pins), .use_latch(use_latch),
      .line(line), .lat(lat), .wd(wd));
   task chk(input string nm, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task wrap_up;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic access(input logic [1:0] o, ix, input logic w,
      input logic [7:0] a, d);
      logic hit;
      int stb;
      logic [3:0] cse;
      hit = 0;
      stb = 0;
      cse = (o == 2'h0) ? 4'hf : (o == 2'h1 || !ix[0]) ? 4'he : 4'hd;
      @(posedge clk);
      opt <= o;
      use_latch <= (o == 2'h0 || o == 2'h3);
      req <= '{write: w, cs_index: ix, addr: {20'h8_4217, a}, wdata: d};
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      for (int n = 1; n <= 8; n++) begin
         @(posedge clk);
         #1;
         chk("resp", resp, n == 7);
         chk("busy ready", ready, 1'b0);
         chk("addr", pins.addr, {20'h8_4217, a});
         if (pins.ale) begin
            hit = 1;
            chk("ale ad", {pins.ad_oe, pins.ad_out}, {8'hff, a});
         end
         if (!(w ? pins.wr_n : pins.rd_n)) stb++;
         chk("idle strobe", w ? pins.rd_n : pins.wr_n, 1'b1);
         if (n >= 4 && n <= 7) begin
            chk("cs", pins.cs_n, cse);
            chk("data ad", pins.ad_oe, w ? 8'hff : 8'h00);
            if (w) chk("wr ad", pins.ad_out, d);
         end
      end
      chk("cs end", pins.cs_n, 4'hf);
      chk("strobe len", stb, 4);
      chk("ale use", hit, o == 2'h0 || o == 2'h3);
      if (w) chk("wdata", wd, d);
      else chk("rdata", rdata, a ^ 8'ha5);
      if (hit) chk("latch", lat, a);
      @(posedge clk);
      #1;
      chk("idle ready", ready, 1'b1);
   endtask : access
   task automatic reads;
      for (int o = 0; o < 4; o++)
         access(o[1:0], o[1:0], 1'b0, 8'(8'h3c + o), 8'h00);
      $display("reads done");
   endtask : reads
   task automatic writes;
      for (int o = 0; o < 4; o++)
         access(o[1:0], {1'b0, ~o[0]}, 1'b1, 8'(8'hc3 ^ o), 8'(8'h5a + o));
      $display("writes done");
   endtask : writes
   task automatic refused(input logic [3:0] tc, hc);
      @(posedge clk);
      top_cfg <= tc;
      hb_cfg <= hc;
      req_valid <= 1'b1;
      repeat (12) begin
         @(posedge clk);
         #1;
         chk("refused", {resp, ready, pins.rd_n, pins.wr_n, pins.ale},
            5'h06);
      end
      @(posedge clk);
      req_valid <= 1'b0;
      top_cfg <= 4'h2;
      hb_cfg <= 4'h0;
      $display("refused %h %h done", tc, hc);
   endtask : refused
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      chk("reset", {pins.ale, pins.rd_n, pins.wr_n, pins.cs_n, pins.ad_oe},
         {3'h3, 4'hf, 8'h00});
      rst <= 1'b0;
      reads();
      writes();
      refused(4'h0, 4'h0);
      refused(4'h2, 4'h1);
      reads();
      wrap_up();
   end
   // Watchdog
   initial begin
      #20000;
      error_cnt++;
      $display("unexpected timeout");
      wrap_up();
   end
endmodule : byte_host_bus_tb
